// >>> verilog/eprm_top.sv
`timescale 1ns/1ps
// How it works
// - Latch boot strap after reset release, hold.
// - Latched strap readable in input status word.
// - Strap low: code over external bus.
// - External data pins carry code data both ways.
// - Strap high: weak pull-ups on data pins.
// - Drive sixteen-bit external address bus.
// - Active-low program memory read strobe.
// - Active-low program memory write strobe.
// - Chip enable off when idle, sleep, no interrupt.
// - Chip enable back once any condition ends.
// - Separate active-low I/O read and write strobes.
// - Card detect input with weak pull-up.
// - Seven pins: input, edge interrupt, output.
// - Trailing N means active low.
module eprm_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Boot source strap pin
    input wire logic BOOT_SOURCE_STRAP,
    // CPU access requests
    input wire logic CPU_CODE_RD,
    input wire logic CPU_CODE_WR,
    input wire logic CPU_IO_RD,
    input wire logic CPU_IO_WR,
    input wire logic [eprm_pkg::ADDR_W-1:0] CPU_ADDR,
    input wire logic [eprm_pkg::DATA_W-1:0] CPU_WDATA,
    output logic CPU_BUSY,
    output logic CPU_RVALID,
    output logic [eprm_pkg::DATA_W-1:0] CPU_RDATA,
    // Power state
    input wire logic CPU_IDLE,
    input wire logic SECOND_EXT_INTERRUPT,
    input wire logic CLK_SLEEP,
    // External memory pins
    output logic [eprm_pkg::ADDR_W-1:0] EXT_MEM_ADDR,
    input wire logic [eprm_pkg::DATA_W-1:0] EXT_MEM_DATA_I,
    output logic [eprm_pkg::DATA_W-1:0] EXT_MEM_DATA_O,
    output logic EXT_MEM_DATA_OE_N,
    output logic EXT_MEM_DATA_PU_EN,
    output logic PROG_MEM_READ_N,
    output logic PROG_MEM_WRITE_N,
    output logic PROG_MEM_CHIP_EN_N,
    output logic XBUS_IO_READ_N,
    output logic XBUS_IO_WRITE_N,
    // Card detect
    input wire logic CARD_PRESENT_N,
    output logic CARD_PULLUP_EN,
    output logic CARD_INSERTED,
    // General-purpose pins
    input wire logic [eprm_pkg::GP_NUM-1:0] GP_PIN_I,
    output logic [eprm_pkg::GP_NUM-1:0] GP_PIN_O,
    output logic [eprm_pkg::GP_NUM-1:0] GP_PIN_OE_N,
    input wire logic [2*eprm_pkg::GP_NUM-1:0] GP_MODE,
    input wire logic [eprm_pkg::GP_NUM-1:0] GP_EDGE_RISE,
    input wire logic [eprm_pkg::GP_NUM-1:0] GP_OUT_VAL,
    input wire logic [eprm_pkg::GP_NUM-1:0] GP_IRQ_CLR,
    output logic [eprm_pkg::GP_NUM-1:0] GP_IRQ_FLAG,
    // Status
    output logic [eprm_pkg::DATA_W-1:0] GP_INPUT_STATUS,
    output logic BOOT_FROM_EXT
);
    import eprm_pkg::*;

    logic [1:0] rst_pipe_reg;
    wire rst_n = rst_pipe_reg[1];
    logic [SYNC_W-1:0] pin_q;
    logic strap_reg;
    logic strap_done_reg;
    logic [1:0] cap_cnt_reg;
    eprm_state_t state_reg;
    eprm_state_t state_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic op_code_reg;
    logic op_read_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic oe_n_reg;
    logic rd_n_reg;
    logic wr_n_reg;
    logic iord_n_reg;
    logic iowr_n_reg;
    logic ce_n_reg;
    logic busy_reg;
    logic rvalid_reg;
    logic pu_reg;
    logic card_reg;
    logic card_pu_reg;
    logic [DATA_W-1:0] status_reg;
    logic boot_ext_reg;
    // Reset release through two flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    // All pin inputs pass two flops
    eprm_sync #(
        .W(SYNC_W),
        .INIT({SYNC_W{1'b1}})
    ) i_eprm_sync (
        .clk(CLK),
        .rst_n(rst_n),
        .d({GP_PIN_I, EXT_MEM_DATA_I, CARD_PRESENT_N, BOOT_SOURCE_STRAP}),
        .q(pin_q)
    );

    wire strap_q = pin_q[SY_STRAP];
    wire card_q = pin_q[SY_CARD];
    wire [DATA_W-1:0] data_q = pin_q[SY_DATA +: DATA_W];
    wire [GP_NUM-1:0] gp_q = pin_q[SY_GP +: GP_NUM];

    // General-purpose pin block
    eprm_gpio_if #(.N(GP_NUM)) gp_if ();
    assign gp_if.mode = GP_MODE;
    assign gp_if.rise = GP_EDGE_RISE;
    assign gp_if.out_val = GP_OUT_VAL;
    assign gp_if.clr = GP_IRQ_CLR;
    assign gp_if.lvl = gp_q;
    eprm_gpio #(
        .GP_N(GP_NUM)
    ) i_eprm_gpio (
        .clk(CLK),
        .rst_n(rst_n),
        .gp(gp_if.pins)
    );
    assign GP_IRQ_FLAG = gp_if.flag;
    assign GP_PIN_O = gp_if.pin_o;
    assign GP_PIN_OE_N = gp_if.pin_oe_n;

    // Strap is taken once the synchroniser holds its level
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            strap_reg <= STRAP_RST;
            strap_done_reg <= 1'b0;
            cap_cnt_reg <= 2'h0;
        end else if (!strap_done_reg) begin
            cap_cnt_reg <= cap_cnt_reg + 2'h1;
            if (cap_cnt_reg == STRAP_WAIT) begin
                strap_reg <= strap_q;
                strap_done_reg <= 1'b1;
            end
        end
    end

    // Power-down of the program memory chip enable
    wire pdown_next = CPU_IDLE & ~SECOND_EXT_INTERRUPT & CLK_SLEEP;

    // Request arbitration: code read, code write, I/O read, I/O write
    wire code_ok = strap_done_reg & ~strap_reg;
    wire take_crd = CPU_CODE_RD & code_ok;
    wire take_cwr = CPU_CODE_WR & code_ok & ~take_crd;
    wire take_ird = CPU_IO_RD & ~take_crd & ~take_cwr;
    wire take_iwr = CPU_IO_WR & ~take_crd & ~take_cwr & ~CPU_IO_RD;
    wire any_take = take_crd | take_cwr | take_ird | take_iwr;
    wire start = (state_reg == ST_IDLE) & ~pdown_next & any_take &
        strap_done_reg;

    // Sequencer; a power-down cancels the access at once
    always_comb begin
        state_next = state_reg;
        if (pdown_next) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: if (start) state_next = ST_SETUP;
                ST_SETUP: state_next = ST_STROBE;
                ST_STROBE: if (cnt_reg == STRB_LAST) state_next = ST_CAPT;
                ST_CAPT: if (cnt_reg == CAPT_LAST) state_next = ST_IDLE;
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // Counter and operation decode for the coming cycle
    assign cnt_next = (state_next == state_reg) ? cnt_reg + 3'h1 : 3'h0;
    wire op_code_next = start ? (take_crd | take_cwr) : op_code_reg;
    wire op_read_next = start ? (take_crd | take_ird) : op_read_reg;
    wire strobe_next = (state_next == ST_STROBE);
    wire drive_next = (state_next != ST_IDLE) & ~op_read_next;
    wire capt_now = (state_reg == ST_CAPT) & (cnt_reg == CAPT_LAST) &
        op_read_reg & ~pdown_next;

    // Strobes: one at a time, only inside the strobe window
    wire rd_n_next = ~(strobe_next & op_code_next & op_read_next);
    wire wr_n_next = ~(strobe_next & op_code_next & ~op_read_next);
    wire iord_n_next = ~(strobe_next & ~op_code_next & op_read_next);
    wire iowr_n_next = ~(strobe_next & ~op_code_next & ~op_read_next);

    // Sequencer state and captured request
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
            op_code_reg <= 1'b0;
            op_read_reg <= 1'b0;
            addr_reg <= '0;
            dout_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            op_code_reg <= op_code_next;
            op_read_reg <= op_read_next;
            if (start) begin
                addr_reg <= CPU_ADDR;
                dout_reg <= CPU_WDATA;
            end
        end
    end

    // Pin drivers, all from flops
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            iord_n_reg <= 1'b1;
            iowr_n_reg <= 1'b1;
            ce_n_reg <= PDOWN_RST;
        end else begin
            oe_n_reg <= ~drive_next;
            rd_n_reg <= rd_n_next;
            wr_n_reg <= wr_n_next;
            iord_n_reg <= iord_n_next;
            iowr_n_reg <= iowr_n_next;
            ce_n_reg <= pdown_next;
        end
    end

    // CPU answer and status
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
            busy_reg <= 1'b1;
            pu_reg <= STRAP_RST;
            card_reg <= 1'b0;
            card_pu_reg <= 1'b1;
            status_reg <= '0;
            boot_ext_reg <= ~STRAP_RST;
        end else begin
            rvalid_reg <= capt_now;
            if (capt_now) begin
                rdata_reg <= data_q;
            end
            busy_reg <= (state_next != ST_IDLE) | ~strap_done_reg;
            pu_reg <= strap_reg;
            card_reg <= ~card_q;
            card_pu_reg <= 1'b1;
            status_reg <= {strap_reg, gp_q};
            boot_ext_reg <= ~strap_reg;
        end
    end

    assign EXT_MEM_ADDR = addr_reg;
    assign EXT_MEM_DATA_O = dout_reg;
    assign EXT_MEM_DATA_OE_N = oe_n_reg;
    assign EXT_MEM_DATA_PU_EN = pu_reg;
    assign PROG_MEM_READ_N = rd_n_reg;
    assign PROG_MEM_WRITE_N = wr_n_reg;
    assign PROG_MEM_CHIP_EN_N = ce_n_reg;
    assign XBUS_IO_READ_N = iord_n_reg;
    assign XBUS_IO_WRITE_N = iowr_n_reg;
    assign CARD_PULLUP_EN = card_pu_reg;
    assign CARD_INSERTED = card_reg;
    assign CPU_BUSY = busy_reg;
    assign CPU_RVALID = rvalid_reg;
    assign CPU_RDATA = rdata_reg;
    assign GP_INPUT_STATUS = status_reg;
    assign BOOT_FROM_EXT = boot_ext_reg;

    default clocking @(posedge CLK); endclocking
    default disable iff (!rst_n);

    // Latched strap never moves after capture
    strap_hold_a: assert property (strap_done_reg |=> $stable(strap_reg))
        else $error("boot strap changed after capture");
    // Status shows the latched strap
    status_boot_a: assert property (strap_done_reg |=>
        GP_INPUT_STATUS[STAT_BOOT_BIT] == $past(strap_reg))
        else $error("status boot bit wrong");
    // Internal boot never strobes program memory
    int_boot_quiet_a: assert property (strap_reg |->
        PROG_MEM_READ_N && PROG_MEM_WRITE_N)
        else $error("program strobe in internal boot");
    // Write strobe only with data driven
    write_drive_a: assert property (!PROG_MEM_WRITE_N |->
        !EXT_MEM_DATA_OE_N && EXT_MEM_DATA_O == dout_reg)
        else $error("write strobe without data");
    // Pull-ups follow the latched strap
    pullup_a: assert property (strap_done_reg |=>
        EXT_MEM_DATA_PU_EN == $past(strap_reg))
        else $error("pull-up enable wrong");
    // Address steady through a read strobe
    addr_steady_a: assert property (!PROG_MEM_READ_N
        && $past(!PROG_MEM_READ_N) |-> $stable(EXT_MEM_ADDR))
        else $error("address moved during strobe");
    // Read strobe leads to data or to power-down
    read_answer_a: assert property ($fell(PROG_MEM_READ_N) |->
        ##[1:5] (CPU_RVALID || PROG_MEM_CHIP_EN_N))
        else $error("read gave no answer");
    // Write strobe ends within its window
    write_end_a: assert property ($fell(PROG_MEM_WRITE_N) |->
        ##[1:3] PROG_MEM_WRITE_N)
        else $error("write strobe too long");
    // Chip enable off one cycle after power-down
    ce_off_a: assert property (pdown_next |=> PROG_MEM_CHIP_EN_N)
        else $error("chip enable not negated");
    // Chip enable back once any condition ends
    ce_on_a: assert property ($past(pdown_next) && !pdown_next
        |=> !PROG_MEM_CHIP_EN_N)
        else $error("chip enable not restored");
    // I/O strobes stay apart from program strobes
    io_apart_a: assert property (!(XBUS_IO_READ_N &&
        XBUS_IO_WRITE_N) |-> PROG_MEM_READ_N && PROG_MEM_WRITE_N)
        else $error("I/O and program strobes overlap");
    // Card presence follows the synchronised pin
    card_follow_a: assert property ($fell(card_q) |=> CARD_INSERTED)
        else $error("card insertion missed");
    // Strobes exclusive and off without chip enable
    strobe_excl_a: assert property (PROG_MEM_CHIP_EN_N ||
        !PROG_MEM_READ_N |-> PROG_MEM_WRITE_N)
        else $error("write strobe overlaps");
    ce_quiet_a: assert property (PROG_MEM_CHIP_EN_N |->
        PROG_MEM_READ_N && PROG_MEM_WRITE_N)
        else $error("strobe while chip disabled");
endmodule

// >>> include/eprm_pkg.sv
package eprm_pkg;
    // Bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int GP_NUM = 7;

    // Timing: strobe width from ns at the core clock rate
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_NS = 30;
    localparam int STRB_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_LAT = 2;
    localparam logic [2:0] STRB_LAST = 3'(STRB_CYC - 1);
    localparam logic [2:0] CAPT_LAST = 3'(SYNC_LAT - 1);
    localparam logic [1:0] STRAP_WAIT = 2'(SYNC_LAT);

    // Reset values
    localparam logic STRAP_RST = 1'b1;
    localparam logic PDOWN_RST = 1'b0;

    // Status word layout
    localparam int STAT_BOOT_BIT = 7;

    // Layout of the pin synchroniser word
    localparam int SY_STRAP = 0;
    localparam int SY_CARD = 1;
    localparam int SY_DATA = 2;
    localparam int SY_GP = SY_DATA + DATA_W;
    localparam int SYNC_W = SY_GP + GP_NUM;

    // General-purpose pin modes
    localparam logic [1:0] GP_MODE_IN = 2'h0;
    localparam logic [1:0] GP_MODE_IRQ = 2'h1;
    localparam logic [1:0] GP_MODE_OUT = 2'h2;

    // Access sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h2,
        ST_STROBE = 4'h4,
        ST_CAPT = 4'h8
    } eprm_state_t;
endpackage

// >>> include/eprm_gpio_if.sv
`timescale 1ns/1ps
interface eprm_gpio_if #(parameter int N = eprm_pkg::GP_NUM);
    logic [2*N-1:0] mode;
    logic [N-1:0] rise;
    logic [N-1:0] out_val;
    logic [N-1:0] clr;
    logic [N-1:0] lvl;
    logic [N-1:0] flag;
    logic [N-1:0] pin_o;
    logic [N-1:0] pin_oe_n;

    modport ctl (
        output mode, rise, out_val, clr, lvl,
        input flag, pin_o, pin_oe_n
    );
    modport pins (
        input mode, rise, out_val, clr, lvl,
        output flag, pin_o, pin_oe_n
    );
endinterface

// >>> verilog/eprm_sync.sv
`timescale 1ns/1ps
module eprm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous inputs and their synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // Two flops; the first is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= INIT;
            q <= INIT;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// >>> verilog/eprm_gpio.sv
`timescale 1ns/1ps
module eprm_gpio #(
    parameter int GP_N = eprm_pkg::GP_NUM
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin control and state
    eprm_gpio_if.pins gp
);
    import eprm_pkg::*;

    logic [GP_N-1:0] prev_reg;
    logic [GP_N-1:0] flag_reg;
    logic [GP_N-1:0] pin_o_reg;
    logic [GP_N-1:0] oe_n_reg;
    wire [GP_N-1:0] hit;

    // Edge seen in the chosen direction
    function automatic logic edge_hit(logic cur, logic old, logic up);
        edge_hit = up ? (cur & ~old) : (~cur & old);
    endfunction

    // Per-pin mode decode, edge detect and drive
    for (genvar i = 0; i < GP_N; i++) begin : g_pin
        wire [1:0] m = gp.mode[2*i +: 2];
        assign hit[i] = (m == GP_MODE_IRQ) &&
            edge_hit(gp.lvl[i], prev_reg[i], gp.rise[i]);

        // Set wins over a clear in the same cycle
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                prev_reg[i] <= 1'b1; // Same level as synchroniser reset
                flag_reg[i] <= 1'b0;
                pin_o_reg[i] <= 1'b0;
                oe_n_reg[i] <= 1'b1;
            end else begin
                prev_reg[i] <= gp.lvl[i];
                flag_reg[i] <= hit[i] | (flag_reg[i] & ~gp.clr[i]);
                pin_o_reg[i] <= gp.out_val[i];
                oe_n_reg[i] <= ~(m == GP_MODE_OUT);
            end
        end
    end

    assign gp.flag = flag_reg;
    assign gp.pin_o = pin_o_reg;
    assign gp.pin_oe_n = oe_n_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Edge in interrupt mode raises the flag
    gp_edge_flag_a: assert property (|hit |=> |(flag_reg & $past(hit)))
        else $error("edge did not set flag");
    // Only output mode drives pin 0
    gp_drive_mode_a: assert property (gp.mode[1:0] != GP_MODE_OUT
        |=> oe_n_reg[0])
        else $error("pin driven outside output mode");
endmodule

// >>> dv/eprm_mem_model.sv
`timescale 1ns/1ps
module eprm_mem_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Memory pins seen from the board
    input wire logic [15:0] addr,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n,
    input wire logic data_pu_en,
    input wire logic prog_rd_n,
    input wire logic prog_wr_n,
    input wire logic ce_n,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    // Level on the data wires
    output logic [7:0] data_i
);
    logic [7:0] mem [0:131071];
    logic [16:0] key, rkey, wkey;
    logic rd, wr, drv;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [1:0] hold = 2'h0;
    logic [7:0] pin_v;
    logic [7:0] last = 8'h00;
    // Code and I/O spaces kept apart by the top key bit
    assign key = {~io_rd_n | ~io_wr_n, addr};
    assign rd = (~prog_rd_n & ~ce_n) | ~io_rd_n;
    assign wr = (~prog_wr_n & ~ce_n) | ~io_wr_n;
    assign drv = slow ? rd_q : rd;
    // Known contents, so that an unwritten place never reads unknown
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 8'(i ^ (i >> 9));
    end
    // Released wires: pull-ups when enabled, else a changing pattern
    always_comb begin
        if (drv) pin_v = mem[slow ? rkey : key];
        else if (hold != 2'h0) pin_v = mem[rkey];
        else if (data_pu_en) pin_v = 8'hff;
        else pin_v = ~last;
    end
    assign data_i = data_oe_n ? pin_v : data_o;
    // Store when a write strobe closes; keep read data 3 cycles after
    always @(posedge clk) begin
        rd_q <= rd;
        wr_q <= wr;
        last <= data_i;
        if (rd) rkey <= key;
        if (wr) wkey <= key;
        if (wr_q && !wr) mem[wkey] <= data_o;
        if (drv) hold <= 2'h3;
        else if (hold != 2'h0) hold <= hold - 2'h1;
    end
endmodule

// >>> dv/eprm_top_bench.sv
`timescale 1ns/1ps
module eprm_top_bench;
    import eprm_pkg::*;
    logic CLK = 1'b0, RESETN = 1'b0, BOOT_SOURCE_STRAP = 1'b0, SLOW = 1'b0;
    logic CPU_CODE_RD = 1'b0, CPU_CODE_WR = 1'b0;
    logic CPU_IO_RD = 1'b0, CPU_IO_WR = 1'b0;
    logic [ADDR_W-1:0] CPU_ADDR = '0, EXT_MEM_ADDR;
    logic [DATA_W-1:0] CPU_WDATA = '0, CPU_RDATA, EXT_MEM_DATA_I;
    logic [DATA_W-1:0] EXT_MEM_DATA_O, GP_INPUT_STATUS;
    logic CPU_BUSY, CPU_RVALID, EXT_MEM_DATA_OE_N, EXT_MEM_DATA_PU_EN;
    logic CPU_IDLE = 1'b0, SECOND_EXT_INTERRUPT = 1'b0, CLK_SLEEP = 1'b0;
    logic PROG_MEM_READ_N, PROG_MEM_WRITE_N, PROG_MEM_CHIP_EN_N;
    logic XBUS_IO_READ_N, XBUS_IO_WRITE_N, CARD_PULLUP_EN, CARD_INSERTED;
    logic CARD_PRESENT_N = 1'b1, BOOT_FROM_EXT;
    logic [GP_NUM-1:0] GP_PIN_I, GP_PIN_O, GP_PIN_OE_N, GP_IRQ_FLAG;
    logic [GP_NUM-1:0] GP_EDGE_RISE = '0, GP_OUT_VAL = '0, GP_IRQ_CLR = '0;
    logic [GP_NUM-1:0] gp_drv = '0;
    logic [2*GP_NUM-1:0] GP_MODE = '0;
    logic [DATA_W-1:0] exp_q [$];
    logic [DATA_W-1:0] shadow [0:131071];
    logic [31:0] seed = 32'hf303;
    int failures = 0, samples_checked = 0;
    // Same starting contents as the memory model
    initial begin
        for (int i = 0; i < 131072; i++) shadow[i] = 8'(i ^ (i >> 9));
    end

    // Clock and the level on the general-purpose wires
    always #5 CLK = ~CLK;
    assign GP_PIN_I = (~GP_PIN_OE_N & GP_PIN_O) | (GP_PIN_OE_N & gp_drv);

    eprm_top i_eprm_top (.CLK(CLK), .RESETN(RESETN),
        .BOOT_SOURCE_STRAP(BOOT_SOURCE_STRAP), .CPU_CODE_RD(CPU_CODE_RD),
        .CPU_CODE_WR(CPU_CODE_WR), .CPU_IO_RD(CPU_IO_RD),
        .CPU_IO_WR(CPU_IO_WR), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
        .CPU_BUSY(CPU_BUSY), .CPU_RVALID(CPU_RVALID), .CPU_RDATA(CPU_RDATA),
        .CPU_IDLE(CPU_IDLE), .SECOND_EXT_INTERRUPT(SECOND_EXT_INTERRUPT),
        .CLK_SLEEP(CLK_SLEEP), .EXT_MEM_ADDR(EXT_MEM_ADDR),
        .EXT_MEM_DATA_I(EXT_MEM_DATA_I), .EXT_MEM_DATA_O(EXT_MEM_DATA_O),
        .EXT_MEM_DATA_OE_N(EXT_MEM_DATA_OE_N),
        .EXT_MEM_DATA_PU_EN(EXT_MEM_DATA_PU_EN),
        .PROG_MEM_READ_N(PROG_MEM_READ_N),
        .PROG_MEM_WRITE_N(PROG_MEM_WRITE_N),
        .PROG_MEM_CHIP_EN_N(PROG_MEM_CHIP_EN_N),
        .XBUS_IO_READ_N(XBUS_IO_READ_N), .XBUS_IO_WRITE_N(XBUS_IO_WRITE_N),
        .CARD_PRESENT_N(CARD_PRESENT_N), .CARD_PULLUP_EN(CARD_PULLUP_EN),
        .CARD_INSERTED(CARD_INSERTED), .GP_PIN_I(GP_PIN_I),
        .GP_PIN_O(GP_PIN_O), .GP_PIN_OE_N(GP_PIN_OE_N), .GP_MODE(GP_MODE),
        .GP_EDGE_RISE(GP_EDGE_RISE), .GP_OUT_VAL(GP_OUT_VAL),
        .GP_IRQ_CLR(GP_IRQ_CLR), .GP_IRQ_FLAG(GP_IRQ_FLAG),
        .GP_INPUT_STATUS(GP_INPUT_STATUS), .BOOT_FROM_EXT(BOOT_FROM_EXT));

    eprm_mem_model i_eprm_mem_model (.clk(CLK), .slow(SLOW),
        .addr(EXT_MEM_ADDR), .data_o(EXT_MEM_DATA_O),
        .data_oe_n(EXT_MEM_DATA_OE_N), .data_pu_en(EXT_MEM_DATA_PU_EN),
        .prog_rd_n(PROG_MEM_READ_N), .prog_wr_n(PROG_MEM_WRITE_N),
        .ce_n(PROG_MEM_CHIP_EN_N), .io_rd_n(XBUS_IO_READ_N),
        .io_wr_n(XBUS_IO_WRITE_N), .data_i(EXT_MEM_DATA_I));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One comparison with its own report line
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Reset for 8 cycles with a given strap level, then let it latch
    task automatic do_reset(input logic strap);
        @(posedge CLK);
        RESETN <= 1'b0;
        BOOT_SOURCE_STRAP <= strap;
        repeat (8) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (10) @(posedge CLK);
        #1;
    endtask

    // One access: 0 code rd, 1 code wr, 2 io rd, 3 io wr
    task automatic req(input int k, input logic [15:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        while (CPU_BUSY !== 1'b0 && n < 50) begin
            @(posedge CLK);
            n++;
        end
        @(posedge CLK);
        CPU_CODE_RD <= (k == 0);
        CPU_CODE_WR <= (k == 1);
        CPU_IO_RD <= (k == 2);
        CPU_IO_WR <= (k == 3);
        CPU_ADDR <= a;
        CPU_WDATA <= d;
        if (k == 0 || k == 2) exp_q.push_back(shadow[{k[1], a}]);
        if (k == 1 || k == 3) shadow[{k[1], a}] = d;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (CPU_BUSY !== 1'b1 && n < 50);
        if (n >= 50) chk("busy_seen", 16'h1, 16'h0);
        {CPU_CODE_RD, CPU_CODE_WR, CPU_IO_RD, CPU_IO_WR} <= 4'h0;
        #1;
    endtask

    // Read data watcher takes the oldest note off the queue
    always @(posedge CLK) begin
        if (CPU_RVALID === 1'b1) begin
            if (exp_q.size() == 0)
                chk("rvalid_unasked", 16'h0, 16'h1);
            else chk("rdata", {8'h00, exp_q.pop_front()}, CPU_RDATA);
        end
    end

    // Strobes never together, and quiet while the chip is disabled
    always @(posedge CLK) begin
        if (RESETN === 1'b1) begin
            if (PROG_MEM_READ_N === 1'b0 && PROG_MEM_WRITE_N === 1'b0)
                chk("strobe_overlap", 16'h0, 16'h1);
            if (PROG_MEM_CHIP_EN_N === 1'b1 &&
                (PROG_MEM_READ_N !== 1'b1 || PROG_MEM_WRITE_N !== 1'b1))
                chk("strobe_without_ce", 16'h0, 16'h1);
        end
    end

    initial begin
        #400000;
        failures++;
        complete_run;
    end

    initial begin
        logic [15:0] a;
        logic [GP_NUM-1:0] v;
        do_reset(1'b0);
        chk("boot_ext", 16'h1, BOOT_FROM_EXT);
        chk("status_boot", 16'h0, GP_INPUT_STATUS[STAT_BOOT_BIT]);
        chk("data_pullup", 16'h0, EXT_MEM_DATA_PU_EN);
        @(posedge CLK);
        BOOT_SOURCE_STRAP <= 1'b1;
        repeat (6) @(posedge CLK);
        #1;
        chk("boot_held", 16'h1, BOOT_FROM_EXT);
        // Code and I/O traffic at random places, back to back
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            a = seed[15:0];
            SLOW = seed[20];
            req(1, a, seed[23:16]);
            req(3, a, ~seed[23:16]);
            req(0, a, 8'h00);
            req(2, a, 8'h00);
            req(0, ~a, 8'h00);
        end
        // Every combination of the three power-down inputs
        for (int i = 0; i < 8; i++) begin
            @(posedge CLK);
            {CPU_IDLE, SECOND_EXT_INTERRUPT, CLK_SLEEP} <= 3'(i);
            repeat (2) @(posedge CLK);
            #1;
            chk("chip_en_n", 16'(i == 5), PROG_MEM_CHIP_EN_N);
        end
        @(posedge CLK);
        {CPU_IDLE, SECOND_EXT_INTERRUPT, CLK_SLEEP} <= 3'h0;
        CARD_PRESENT_N <= 1'b0;
        repeat (5) @(posedge CLK);
        #1;
        chk("card_in", 16'h1, CARD_INSERTED);
        chk("card_pullup", 16'h1, CARD_PULLUP_EN);
        // Pin 0 output, pin 1 rising-edge interrupt, pin 6 input code 3
        seed = lfsr_next(seed);
        @(posedge CLK);
        GP_MODE <= {2'h3, 8'h00, GP_MODE_IRQ, GP_MODE_OUT};
        GP_EDGE_RISE <= 7'h02;
        GP_OUT_VAL <= seed[6:0];
        gp_drv <= 7'h00;
        repeat (4) @(posedge CLK);
        #1;
        chk("gp_oe_n", 16'h7e, GP_PIN_OE_N);
        chk("gp_out", 16'(seed[0]), GP_PIN_O[0]);
        v = seed[13:7] & 7'h7c;
        @(posedge CLK);
        gp_drv <= v | 7'h02;
        repeat (6) @(posedge CLK);
        #1;
        chk("gp_flag", 16'h02, GP_IRQ_FLAG);
        chk("gp_status", 16'(v), GP_INPUT_STATUS[6:0] & 7'h7c);
        @(posedge CLK);
        GP_IRQ_CLR <= 7'h02;
        repeat (2) @(posedge CLK);
        GP_IRQ_CLR <= 7'h00;
        repeat (2) @(posedge CLK);
        #1;
        chk("gp_flag_clr", 16'h0, GP_IRQ_FLAG);
        // Pin 1 turned to falling edge: drop it and expect the flag again
        @(posedge CLK);
        GP_EDGE_RISE <= 7'h00;
        gp_drv <= v;
        repeat (6) @(posedge CLK);
        #1;
        chk("gp_flag_fall", 16'h02, GP_IRQ_FLAG);
        // Second reset with the strap high: internal code only
        do_reset(1'b1);
        chk("boot_int", 16'h0, BOOT_FROM_EXT);
        chk("status_boot", 16'h1, GP_INPUT_STATUS[STAT_BOOT_BIT]);
        chk("data_pullup", 16'h1, EXT_MEM_DATA_PU_EN);
        @(posedge CLK);
        CPU_CODE_RD <= 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        chk("code_refused", 16'h0, CPU_BUSY);
        @(posedge CLK);
        CPU_CODE_RD <= 1'b0;
        req(3, 16'h0123, 8'ha5);
        req(2, 16'h0123, 8'h00);
        repeat (10) @(posedge CLK);
        chk("queue_empty", 16'h0, 16'(exp_q.size()));
        complete_run;
    end
endmodule
